// >>> bench/magctl_asserts.sv
// Checker for the legacy-mode magnetometer controller ports.
// Assumes the bench keeps the serial clock slow against the system clock.
`timescale 1ns/1ps
module magctl_asserts (
    input wire i_clock,
    input wire i_reset_n,
    input wire i_sck,
    input wire i_chip_select_n,
    input wire o_miso_oe,
    input wire o_result_ready,
    input wire [2:0] o_axis_enable,
    input wire o_bias_reverse,
    input wire o_comp_enable,
    input wire o_legacy_active
);
    // ----------------------------------------
    // Helper logic
    // ----------------------------------------
    // Cycles since the last serial clock rise; saturates so it never wraps.
    reg [3:0] sck_age;
    reg sck_last;
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sck_age <= 4'hf;
            sck_last <= 1'b0;
        end else begin
            sck_last <= i_sck;
            if (i_sck && !sck_last)
                sck_age <= 4'h0;
            else if (sck_age != 4'hf)
                sck_age <= sck_age + 4'h1;
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    sequence s_deselected;
        i_chip_select_n [*6];
    endsequence
    sequence s_read_start;
        $rose(i_sck) && o_result_ready;
    endsequence
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    a_oe_needs_legacy: assert property (!o_legacy_active |-> !o_miso_oe)
        else $error("miso driven outside legacy mode");
    a_one_axis_only: assert property ($onehot0(o_axis_enable))
        else $error("several axes enabled");
    a_ready_drops_read: assert property (s_read_start |-> ##[1:8] !o_result_ready)
        else $error("ready kept during readout");
    a_ready_fall_cause: assert property ($fell(o_result_ready) |-> sck_age <= 4'h8)
        else $error("ready fell without serial clock");
    a_test_runs_osc: assert property ($rose(o_comp_enable) |-> o_axis_enable != 3'h0)
        else $error("test mode without oscillator");
    a_start_forward: assert property (
        $rose(|o_axis_enable) |-> !o_bias_reverse || o_comp_enable)
        else $error("measurement started in reverse");
    a_ready_idles: assert property ($rose(o_result_ready) |-> ##1 o_axis_enable == 3'h0)
        else $error("oscillator still on when ready");
    a_release_oe: assert property (s_deselected |-> !o_miso_oe)
        else $error("miso driven while deselected");
endmodule // magctl_asserts

bind compat_mode_magnetometer_ctrl magctl_asserts i_chk (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_sck(i_sck),
    .i_chip_select_n(i_chip_select_n), .o_miso_oe(o_miso_oe),
    .o_result_ready(o_result_ready), .o_axis_enable(o_axis_enable),
    .o_bias_reverse(o_bias_reverse), .o_comp_enable(o_comp_enable),
    .o_legacy_active(o_legacy_active)
);

// >>> bench/spi_host_model.sv
// Serial host model, clock polarity zero, MSB first.
// Assumes the bench calls its tasks; clock half period is five cycles.
`timescale 1ns/1ps
module spi_host_model (
    input wire i_clock,
    input wire i_miso,
    output reg o_sck,
    output reg o_cs_n,
    output reg o_mosi
);
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end
    // A released data line toggles so a stale value cannot pass.
    always @(posedge i_clock) begin
        if (o_cs_n)
            o_mosi <= #2 ~o_mosi;
    end
    task step(input integer n);
        repeat (n) @(posedge i_clock);
        #2;
    endtask
    task sel(input v);
        step(1);
        o_cs_n = v;
        step(6);
    endtask
    // Sample late in the high phase; the slave moves data after the fall.
    task bit_x(input b, output r);
        o_mosi = b;
        step(5);
        o_sck = 1'b1;
        step(5);
        r = i_miso;
        o_sck = 1'b0;
    endtask
    task byte_x(input [7:0] tx, output [7:0] rx);
        integer i;
        for (i = 7; i >= 0; i = i - 1)
            bit_x(tx[i], rx[i]);
        step(5);
    endtask
    task word_x(output [15:0] rx);
        integer i;
        for (i = 15; i >= 0; i = i - 1)
            bit_x(1'b0, rx[i]);
        step(5);
    endtask
endmodule // spi_host_model

// >>> bench/tb.sv
// Self-checking bench for the legacy-mode magnetometer controller.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ps
module tb;
    reg i_clock = 1'b0, i_reset_n = 1'b0, i_clear = 1'b0, osc = 1'b0, legacy_mode = 1'b1;
    wire sck, cs_n, mosi, o_miso, o_miso_oe, o_result_ready;
    wire o_bias_reverse, o_comp_enable, o_legacy_active;
    wire [2:0] o_axis_enable;
    integer bad_count = 0, samples_checked = 0, pf = 8, pr = 4, cnt = 0;
    reg [7:0] r8;
    reg [15:0] r16;
    compat_mode_magnetometer_ctrl i_dut (.i_clock(i_clock), .i_reset_n(i_reset_n),
        .i_sck(sck), .i_chip_select_n(cs_n), .i_mosi(mosi), .i_clear(i_clear),
        .i_legacy_mode(legacy_mode), .i_sensor_osc(osc), .o_miso(o_miso),
        .o_miso_oe(o_miso_oe), .o_result_ready(o_result_ready),
        .o_axis_enable(o_axis_enable), .o_bias_reverse(o_bias_reverse),
        .o_comp_enable(o_comp_enable), .o_legacy_active(o_legacy_active));
    spi_host_model i_host (.i_clock(i_clock), .i_miso(o_miso), .o_sck(sck),
        .o_cs_n(cs_n), .o_mosi(mosi));
    initial forever #12.5 i_clock = ~i_clock;
    // Sensor oscillator: period depends on bias, still while no axis is on.
    always @(posedge i_clock) begin
        #2;
        if (o_axis_enable == 3'h0) begin
            osc = 1'b0;
            cnt = 0;
        end else begin
            cnt = cnt + 1;
            if (cnt >= (o_bias_reverse ? pr : pf) / 2) begin
                osc = ~osc;
                cnt = 0;
            end
        end
    end
    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task check(input [15:0] seen, input [15:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge i_clock);
        bad_count = bad_count + 1;
        conclude;
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task reg_read(input [7:0] exp);
        i_host.sel(1'b0);
        check(o_miso_oe, 1'b1);
        i_host.byte_x(8'hc0, r8);
        check(r8, 8'h5a);
        i_host.byte_x(8'h00, r8);
        check(r8, exp);
        i_host.sel(1'b1);
        $display("register read done");
    endtask
    task reg_write(input [7:0] v);
        i_host.sel(1'b0);
        i_host.byte_x(8'h80, r8);
        i_host.byte_x(v, r8);
        i_host.sel(1'b1);
    endtask
    // Expected difference allows a few ticks of synchroniser jitter.
    task meas(input [7:0] cmd, input [2:0] axis, input integer expd);
        integer n, d;
        i_host.sel(1'b0);
        i_host.byte_x(cmd, r8);
        check(r8, 8'h5a);
        i_host.sel(1'b1);
        check(o_axis_enable, axis);
        for (n = 0; n < 20000 && o_result_ready !== 1'b1; n = n + 1)
            i_host.step(1);
        check(o_result_ready, 1'b1);
        i_host.sel(1'b0);
        i_host.word_x(r16);
        i_host.sel(1'b1);
        check(o_result_ready, 1'b0);
        d = $signed(r16) - expd;
        check(d >= -4 && d <= 4, 1'b1);
        $display("measure %h done", cmd);
    endtask
    task nop_read(input integer expd);
        integer d;
        i_host.sel(1'b0);
        i_host.byte_x(8'h00, r8);
        i_host.step(20);
        check(o_axis_enable, 3'h0);
        i_host.word_x(r16);
        i_host.sel(1'b1);
        d = $signed(r16) - expd;
        check(d >= -4 && d <= 4, 1'b1);
        $display("no-op readback done");
    endtask
    // Mode input low: serial side stays silent and a command is not taken.
    task mode_off;
        legacy_mode = 1'b0;
        i_host.step(4);
        check(o_legacy_active, 1'b0);
        i_host.sel(1'b0);
        check(o_miso_oe, 1'b0);
        i_host.byte_x(8'h01, r8);
        i_host.step(6);
        check(o_axis_enable, 3'h0);
        i_host.sel(1'b1);
        legacy_mode = 1'b1;
        i_host.step(4);
        check(o_legacy_active, 1'b1);
        $display("mode select done");
    endtask
    task test_mode;
        i_host.sel(1'b0);
        i_host.byte_x(8'h0e, r8);
        i_host.step(6);
        check({o_comp_enable, o_axis_enable, o_bias_reverse}, 5'h15);
        i_host.byte_x(8'h06, r8);
        i_host.step(6);
        check(o_bias_reverse, 1'b0);
        i_clear = 1'b1;
        i_host.step(6);
        i_clear = 1'b0;
        check(o_comp_enable, 1'b0);
        i_host.byte_x(8'h07, r8);
        i_host.step(6);
        check(o_comp_enable, 1'b1);
        i_host.byte_x(8'h04, r8);
        i_host.step(6);
        check({o_comp_enable, o_axis_enable}, 4'h0);
        i_host.sel(1'b1);
        $display("oscillator test done");
    endtask
    initial begin
        repeat (12) @(posedge i_clock);
        #2 i_reset_n = 1'b1;
        i_host.step(8);
        i_clear = 1'b1;
        i_host.step(4);
        i_clear = 1'b0;
        reg_read(8'h04);
        meas(8'h01, 3'h1, 8);
        meas(8'h02, 3'h2, 8);
        meas(8'h03, 3'h4, 8);
        nop_read(8);
        reg_write(8'h13);
        reg_read(8'h13);
        meas(8'h11, 3'h1, 16);
        reg_write(8'hff);
        reg_read(8'h77);
        meas(8'h73, 3'h4, 64);
        pf = 4;
        pr = 8;
        reg_write(8'h00);
        meas(8'h01, 3'h1, -128);
        mode_off;
        test_mode;
        conclude;
    end
endmodule // tb

// >>> rtl/compat_mode_magnetometer_ctrl.v
// Legacy-mode measurement controller of a three-axis magnetic sensor.
// Assumes sensor oscillator pulses arrive on a pin and are synchronised here.
// What this block does
// - Bit 7 picks measurement or register access
// - Period select gives 32 shifted by field
// - Direction bit used only in test
// - Test runs oscillator, forces comparator output
// - Test mode: no readout, next command immediately
// - Test ends on measure, clear, nop
// - Axis code: none, X, Y, Z
// - No-op axis keeps previous result
// - Bit 6 selects register read or write
// - Clock divide code 1,2,4,8,16
// - Default reference divide by sixteen
// - Period divide code reduces counted cycles
// - Result is 16-bit two's complement
// - Forward count, reverse count, difference
// - One axis per command only
// - Fixed byte out during command byte
// - Measurement continues if select released
// - Completion raises ready and idles
// - Sixteen clocks shift the result out
// - Serial clock idles low
// - Legacy only with mode input high
`timescale 1ns/1ps
`include "magctl_defines.vh"
module compat_mode_magnetometer_ctrl (
    input wire i_clock,
    input wire i_reset_n,
    input wire i_sck,
    input wire i_chip_select_n,
    input wire i_mosi,
    input wire i_clear,
    input wire i_legacy_mode,
    input wire i_sensor_osc,
    output reg o_miso,
    output reg o_miso_oe,
    output reg o_result_ready,
    output reg [2:0] o_axis_enable,
    output reg o_bias_reverse,
    output reg o_comp_enable,
    output reg o_legacy_active
);
    localparam ST_IDLE = 5'h01;
    localparam ST_FWD = 5'h02;
    localparam ST_REV = 5'h04;
    localparam ST_DONE = 5'h08;
    localparam ST_TEST = 5'h10;

    // Power-of-two decode of the clock divide field; the period divide field uses div_shift.
    function [4:0] div_decode;
        input [2:0] code;
        begin
            case (code)
                3'h0: div_decode = 5'h01;
                3'h1: div_decode = 5'h02;
                3'h2: div_decode = 5'h04;
                3'h3: div_decode = 5'h08;
                default: div_decode = 5'h10;
            endcase
        end
    endfunction

    function [2:0] div_shift;
        input [2:0] code;
        begin
            div_shift = code[2] ? 3'h4 : code;
        end
    endfunction

    // One-hot oscillator enable for an axis code; the no-op code enables nothing.
    function [2:0] axis_onehot;
        input [1:0] code;
        begin
            case (code)
                `AXIS_X: axis_onehot = 3'h1;
                `AXIS_Y: axis_onehot = 3'h2;
                `AXIS_Z: axis_onehot = 3'h4;
                default: axis_onehot = 3'h0;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    reg [1:0] sck_sync, cs_sync, mosi_sync, clear_sync, mode_sync, osc_sync;
    reg osc_prev;
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sck_sync <= 2'h0;
            cs_sync <= 2'h3;
            mosi_sync <= 2'h0;
            clear_sync <= 2'h0;
            mode_sync <= 2'h0;
            osc_sync <= 2'h0;
            osc_prev <= 1'b0;
        end else begin
            sck_sync <= {sck_sync[0], i_sck};
            cs_sync <= {cs_sync[0], i_chip_select_n};
            mosi_sync <= {mosi_sync[0], i_mosi};
            clear_sync <= {clear_sync[0], i_clear};
            mode_sync <= {mode_sync[0], i_legacy_mode};
            osc_sync <= {osc_sync[0], i_sensor_osc};
            osc_prev <= osc_sync[1];
        end
    end

    wire cs_n = cs_sync[1];
    wire clear = clear_sync[1];
    wire legacy = mode_sync[1];
    wire osc_rise = osc_sync[1] & ~osc_prev;

    // ------------------------------------------------------------
    // Serial slave and reference divider
    // ------------------------------------------------------------
    reg [4:0] state;
    reg [7:0] legacy_clock_setting;
    reg [15:0] result;
    reg [15:0] load_word;
    reg load;
    wire [7:0] cmd;
    wire cmd_valid;
    wire first_edge;
    wire spi_miso;
    wire ref_tick;
    wire measuring = (state == ST_FWD) || (state == ST_REV);

    magctl_spi_slave u_spi (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_sck(sck_sync[1]),
        .i_cs_n(cs_n | ~legacy),
        .i_mosi(mosi_sync[1]),
        .i_load_word(load_word),
        .i_load(load),
        .o_miso(spi_miso),
        .o_byte(cmd),
        .o_byte_valid(cmd_valid),
        .o_first_edge(first_edge)
    );

    magctl_clock_divider u_div (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_run(measuring),
        .i_divisor(div_decode(legacy_clock_setting[`CSR_CD_HI:`CSR_CD_LO])),
        .o_tick(ref_tick)
    );

    // ------------------------------------------------------------
    // Command decode and measurement sequencer
    // ------------------------------------------------------------
    reg [12:0] period_target;
    reg [12:0] period_count;
    reg [15:0] fwd_time;
    reg [15:0] time_count;
    reg [4:0] out_count;
    reg reading;
    reg pending_read;
    reg pending_write;
    wire is_reg = cmd[`CMD_REG_FLAG_BIT];
    // Bytes framed during a result readout are data slots, never commands.
    wire cmd_accept = cmd_valid && legacy && !reading;
    wire [1:0] cmd_axis = cmd[`CMD_AXIS_HI:`CMD_AXIS_LO];
    wire [2:0] ps = cmd[`CMD_PS_HI:`CMD_PS_LO];
    wire [2:0] pd = legacy_clock_setting[`CSR_PCS_HI:`CSR_PCS_LO];
    // Shift form avoids a divider; 32<<0 over 16 never drops below 2 cycles.
    wire [12:0] next_target = (`PERIOD_BASE << ps) >> div_shift(pd);

    // Single sequencer guarantees only one axis measures at a time.
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= ST_IDLE;
            legacy_clock_setting <= `CSR_RESET;
            result <= 16'h0000;
            load_word <= {`CMD_ECHO_BYTE, 8'h00};
            load <= 1'b0;
            period_target <= 13'h0000;
            period_count <= 13'h0000;
            fwd_time <= 16'h0000;
            time_count <= 16'h0000;
            out_count <= 5'h00;
            reading <= 1'b0;
            pending_read <= 1'b0;
            pending_write <= 1'b0;
            o_result_ready <= 1'b0;
            o_axis_enable <= 3'h0;
            o_bias_reverse <= 1'b0;
            o_comp_enable <= 1'b0;
            o_miso <= 1'b0;
            o_miso_oe <= 1'b0;
            o_legacy_active <= 1'b0;
        end else begin
            load <= 1'b0;
            o_legacy_active <= legacy;
            o_miso <= spi_miso;
            o_miso_oe <= ~cs_n & legacy;
            if (clear && state == ST_TEST) begin
                state <= ST_IDLE;
                o_axis_enable <= 3'h0;
                o_comp_enable <= 1'b0;
            end
            // Readout: first edge after ready clears the flag, 16 bits go out.
            if (first_edge && reading) begin
                o_result_ready <= 1'b0;
                if (out_count == `RESULT_BITS - 5'h01) begin
                    reading <= 1'b0;
                    load <= 1'b1;
                    load_word <= {`CMD_ECHO_BYTE, 8'h00};
                end
                out_count <= out_count + 5'h01;
            end
            // Register-access byte pairs with the next byte (write data or read slot).
            if (cmd_valid && legacy && pending_read) begin
                pending_read <= 1'b0;
                if (pending_write) begin
                    legacy_clock_setting <= cmd & `CSR_WRITE_MASK;
                end
                load <= 1'b1;
                load_word <= {`CMD_ECHO_BYTE, 8'h00};
            end else if (cmd_accept && (state == ST_IDLE || state == ST_TEST)) begin
                o_result_ready <= 1'b0;
                reading <= 1'b0;
                load <= 1'b1;
                if (is_reg) begin
                    // Next byte is the data slot; bits 5:0 are left undecoded.
                    pending_read <= 1'b1;
                    pending_write <= ~cmd[`CMD_RW_BIT];
                    if (cmd[`CMD_RW_BIT]) begin
                        load_word <= {legacy_clock_setting, 8'h00};
                    end else begin
                        load_word <= {`CMD_ECHO_BYTE, 8'h00};
                    end
                end else if (cmd_axis == `AXIS_NOP) begin
                    state <= ST_IDLE;
                    o_axis_enable <= 3'h0;
                    o_comp_enable <= 1'b0;
                    load_word <= result;
                    reading <= 1'b1;
                    out_count <= 5'h00;
                end else if (cmd[`CMD_MOT_BIT]) begin
                    state <= ST_TEST;
                    o_axis_enable <= axis_onehot(cmd_axis);
                    o_bias_reverse <= cmd[`CMD_OSCILLATOR_DIRECTION_BIT];
                    o_comp_enable <= 1'b1;
                    load_word <= {`CMD_ECHO_BYTE, 8'h00};
                end else begin
                    state <= ST_FWD;
                    o_axis_enable <= axis_onehot(cmd_axis);
                    o_bias_reverse <= 1'b0;
                    o_comp_enable <= 1'b0;
                    period_target <= next_target;
                    period_count <= 13'h0000;
                    time_count <= 16'h0000;
                    load_word <= {`CMD_ECHO_BYTE, 8'h00};
                end
            end
            // Select is not watched here, so releasing it cannot stop a run.
            case (state)
                ST_IDLE: begin
                end
                ST_FWD, ST_REV: begin
                    if (ref_tick) begin
                        time_count <= time_count + 16'h0001;
                    end
                    if (osc_rise) begin
                        if (period_count == period_target - 13'h0001) begin
                            period_count <= 13'h0000;
                            if (state == ST_FWD) begin
                                fwd_time <= time_count;
                                time_count <= 16'h0000;
                                o_bias_reverse <= 1'b1;
                                state <= ST_REV;
                            end else begin
                                // Wraps modulo 2^16, matching the signed range.
                                result <= fwd_time - time_count;
                                state <= ST_DONE;
                            end
                        end else begin
                            period_count <= period_count + 13'h0001;
                        end
                    end
                end
                ST_DONE: begin
                    o_result_ready <= 1'b1;
                    o_axis_enable <= 3'h0;
                    o_bias_reverse <= 1'b0;
                    load <= 1'b1;
                    load_word <= result;
                    reading <= 1'b1;
                    out_count <= 5'h00;
                    state <= ST_IDLE;
                end
                ST_TEST: begin
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
    // A new command taken in the same cycle as clear wins, its assignments coming later; needs no check.
endmodule // compat_mode_magnetometer_ctrl

// >>> rtl/magctl_clock_divider.v
// Enable-pulse divider for the measurement reference clock.
// Assumes the divisor is held stable while a measurement runs.
`timescale 1ns/1ps
module magctl_clock_divider (
    input wire i_clock,
    input wire i_reset_n,
    input wire i_run,
    input wire [4:0] i_divisor,
    output reg o_tick
);
    reg [4:0] count;

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    // One tick every divisor cycles while running; a pulse, not a clock, to stay single domain.
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count <= 5'h00;
            o_tick <= 1'b0;
        end else if (!i_run) begin
            count <= 5'h00;
            o_tick <= 1'b0;
        end else if (count >= i_divisor - 5'h01) begin
            count <= 5'h00;
            o_tick <= 1'b1;
        end else begin
            count <= count + 5'h01;
            o_tick <= 1'b0;
        end
    end
endmodule // magctl_clock_divider

// >>> rtl/magctl_defines.vh
// Constants for the legacy-mode magnetometer measurement controller.
// Included by the controller and serial slave files; holds definitions only.
`ifndef MAGCTL_DEFINES_VH
`define MAGCTL_DEFINES_VH
// Command byte fields.
`define CMD_REG_FLAG_BIT 7
`define CMD_RW_BIT 6
`define CMD_PS_HI 6
`define CMD_PS_LO 4
`define CMD_OSCILLATOR_DIRECTION_BIT 3
`define CMD_MOT_BIT 2
`define CMD_AXIS_HI 1
`define CMD_AXIS_LO 0
// Axis codes.
`define AXIS_NOP 2'h0
`define AXIS_X 2'h1
`define AXIS_Y 2'h2
`define AXIS_Z 2'h3
// Clock-setting register fields and reset value.
`define CSR_CD_HI 2
`define CSR_CD_LO 0
`define CSR_PCS_HI 6
`define CSR_PCS_LO 4
`define CSR_WRITE_MASK 8'h77
`define CSR_RESET 8'h04
// Base cycle count for period select zero.
`define PERIOD_BASE 13'h0020
// Fixed byte shifted out during the command byte (arbitrary value).
`define CMD_ECHO_BYTE 8'h5a
// Serial frame lengths.
`define CMD_BITS 4'h8
`define RESULT_BITS 5'h10
`endif

// >>> rtl/magctl_spi_slave.v
// Serial slave, mode 0 (clock idles low), shifting MSB first.
// Assumes serial pins are already synchronised to i_clock by the parent.
`timescale 1ns/1ps
`include "magctl_defines.vh"
module magctl_spi_slave (
    input wire i_clock,
    input wire i_reset_n,
    input wire i_sck,
    input wire i_cs_n,
    input wire i_mosi,
    input wire [15:0] i_load_word,
    input wire i_load,
    output reg o_miso,
    output reg [7:0] o_byte,
    output reg o_byte_valid,
    output reg o_first_edge
);
    reg sck_prev;
    reg [7:0] shift_in;
    reg [3:0] bit_count;
    reg [15:0] shift_out;
    reg hold_fall;
    wire rise;
    wire fall;

    assign rise = i_sck & ~sck_prev & ~i_cs_n;
    assign fall = ~i_sck & sck_prev & ~i_cs_n;

    // ------------------------------------------------------------
    // Shift engine
    // ------------------------------------------------------------
    // Sample on rising edge, present next bit on falling edge.
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sck_prev <= 1'b0;
            shift_in <= 8'h00;
            bit_count <= 4'h0;
            shift_out <= {`CMD_ECHO_BYTE, 8'h00}; // The first command byte echoes too.
            hold_fall <= 1'b0;
            o_miso <= 1'b0;
            o_byte <= 8'h00;
            o_byte_valid <= 1'b0;
            o_first_edge <= 1'b0;
        end else begin
            sck_prev <= i_sck;
            o_byte_valid <= 1'b0;
            o_first_edge <= rise;
            if (i_cs_n) begin
                bit_count <= 4'h0; // A released select restarts byte framing.
            end
            // A word loaded after the closing rise must survive the closing fall.
            if (rise) begin
                hold_fall <= 1'b0;
            end
            if (i_load) begin
                shift_out <= i_load_word;
                o_miso <= i_load_word[15];
                hold_fall <= 1'b1;
            end else if (fall && !hold_fall) begin
                shift_out <= {shift_out[14:0], 1'b0};
                o_miso <= shift_out[14];
            end
            if (rise) begin
                shift_in <= {shift_in[6:0], i_mosi};
                if (bit_count == `CMD_BITS - 4'h1) begin
                    bit_count <= 4'h0;
                    o_byte <= {shift_in[6:0], i_mosi};
                    o_byte_valid <= 1'b1;
                end else begin
                    bit_count <= bit_count + 4'h1;
                end
            end
        end
    end
endmodule // magctl_spi_slave
